// file: eic_pkg.sv
`default_nettype none
package eic_pkg;
   // frame layout
   localparam int FRAME_BITS = 16;
   localparam logic [4:0] FRAME_CNT = 5'h10;
   localparam int RW_POS = 15;
   localparam int ADDR_HI_POS = 14;
   localparam int ADDR_LO_POS = 13;
   localparam int DATA_BITS = 13;
   localparam logic RW_READ = 1'h0;
   localparam logic RW_WRITE = 1'h1;
   // register addresses
   localparam logic [1:0] REG_CMD = 2'h0;
   localparam logic [1:0] REG_DIAG = 2'h1;
   localparam logic [1:0] REG_STAT = 2'h2;
   // command register fields
   localparam int CMD_CHAN2_POS = 0;
   localparam int CMD_CHAN4_POS = 1;
   localparam int CMD_CHAN5_POS = 2;
   localparam int CMD_LOAD_LO_POS = 9;
   localparam int CMD_THRESH_LO_POS = 11;
   // sensor load: 75k, 4.5k, 2.2k, 1.2k ohm
   localparam logic [1:0] LOAD_75K = 2'h0;
   localparam logic [1:0] LOAD_4K5 = 2'h1;
   localparam logic [1:0] LOAD_2K2 = 2'h2;
   localparam logic [1:0] LOAD_1K2 = 2'h3;
   // sensor threshold: -50mV, -100mV, -500mV, -1V
   localparam logic [1:0] THR_50MV = 2'h0;
   localparam logic [1:0] THR_100MV = 2'h1;
   localparam logic [1:0] THR_500MV = 2'h2;
   localparam logic [1:0] THR_1V = 2'h3;
   // status register fields
   localparam int STAT_CHAN_LO_POS = 0;
   localparam int STAT_WD_EXP_POS = 11;
   localparam int STAT_WD_OFF_POS = 12;
   // reset values
   localparam logic [12:0] DIAG_RST = 13'h0000;
   localparam logic [12:0] STAT_RST = 13'h0000;
   localparam logic [15:0] CMD_RST = 16'h0000;

   typedef struct packed {
      logic [1:0] sensor_thresh_sel;
      logic [1:0] sensor_load_sel;
      logic chan5_on_ctl;
      logic chan4_on_ctl;
      logic chan2_on_ctl;
   } eic_cmd_s;

   typedef struct packed {
      logic rw;
      logic [1:0] addr;
   } eic_hdr_s;
endpackage : eic_pkg
`default_nettype wire

// file: eic_spi_regs.sv
// Notes on behaviour
// - top bit read/write, then two address bits
// - address 00 selects writable command register
// - address 01 selects read-only diagnosis register
// - address 10 selects read-only status register
// - all registers read zero after reset
// - command bits 0..2 switch channels 2,4,5
// - command bits 10:9 select sensor load
// - command bits 12:11 select sensor threshold
// - diagnosis open-load bits 0,5,8,10
// - diagnosis over-current bits 1,3,6,9,11
// - diagnosis over-temperature bits 2,4,7,12
// - status bits 0..4 show channel on states
// - status bit 11 shows watchdog expired
// - status bit 12 mirrors watchdog-off pin
// - frames not exactly sixteen bits discarded
// - reply comes during the following frame
// - invalid frame makes next reply diagnosis
// - before first clock, output shows any-diagnosis
`default_nettype none
module eic_spi_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // serial link pins
   input wire logic spi_clk_i,
   input wire logic spi_cs_n_i,
   input wire logic spi_din_i,
   output logic spi_dout_o,
   output logic spi_dout_oe_o,
   // detector and status inputs
   input wire logic [12:0] diag_det_i,
   input wire logic [4:0] chan_on_i,
   input wire logic wd_expired_i,
   input wire logic wd_off_pin_i,
   // command outputs
   output eic_pkg::eic_cmd_s cmd_o
);

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers: {si, sclk, cs_n, diag, chan, wd_exp, wd_off}
   localparam int IN_W = 23;
   // reset matches idle pins (select high, clock low) so release makes no false edge
   localparam logic [22:0] SYNC_RST = 23'h100000;

   logic [IN_W-1:0] in_raw;
   logic [IN_W-1:0] sync1_q;
   logic [IN_W-1:0] sync2_q;
   logic cs_prev_q;
   logic sclk_prev_q;

   assign in_raw = {spi_din_i, spi_clk_i, spi_cs_n_i, diag_det_i, chan_on_i, wd_expired_i, wd_off_pin_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_q <= SYNC_RST;
         sync2_q <= SYNC_RST;
         cs_prev_q <= 1'h1;
         sclk_prev_q <= 1'h0;
      end else begin
         sync1_q <= in_raw;
         sync2_q <= sync1_q;
         cs_prev_q <= sync2_q[20];
         sclk_prev_q <= sync2_q[21];
      end
   end

   logic si_s;
   logic sclk_s;
   logic cs_n_s;
   logic [12:0] det_s;
   logic [4:0] chan_s;
   logic wd_exp_s;
   logic wd_off_s;

   assign si_s = sync2_q[22];
   assign sclk_s = sync2_q[21];
   assign cs_n_s = sync2_q[20];
   assign det_s = sync2_q[19:7];
   assign chan_s = sync2_q[6:2];
   assign wd_exp_s = sync2_q[1];
   assign wd_off_s = sync2_q[0];

   logic cs_fall;
   logic cs_rise;
   logic sclk_rise;
   logic sclk_fall;

   assign cs_fall = cs_prev_q & ~cs_n_s;
   assign cs_rise = ~cs_prev_q & cs_n_s;
   // edges seen only while selected: link is ignored when deselected
   assign sclk_rise = ~cs_n_s & ~cs_prev_q & ~sclk_prev_q & sclk_s;
   assign sclk_fall = ~cs_n_s & ~cs_prev_q & sclk_prev_q & ~sclk_s;

   ////////////////////////////////////////////////////////////////////////
   // frame shift and count
   logic [15:0] rx_q;
   logic [4:0] cnt_q;
   logic [15:0] tx_q;
   logic so_q;
   logic oe_q;

   logic rx_rw;
   logic [1:0] rx_addr;
   logic len_ok;
   logic is_write_cmd;
   logic is_read_ok;
   logic frame_valid;
   logic do_write;
   logic do_read_diag;

   assign rx_rw = rx_q[eic_pkg::RW_POS];
   assign rx_addr = rx_q[eic_pkg::ADDR_HI_POS:eic_pkg::ADDR_LO_POS];
   assign len_ok = (cnt_q == eic_pkg::FRAME_CNT);
   // only the command register takes writes
   assign is_write_cmd = (rx_rw == eic_pkg::RW_WRITE) && (rx_addr == eic_pkg::REG_CMD);
   assign is_read_ok = (rx_rw == eic_pkg::RW_READ) && (rx_addr != 2'h3);
   assign frame_valid = is_write_cmd | is_read_ok;
   assign do_write = cs_rise & len_ok & is_write_cmd;
   assign do_read_diag = cs_rise & len_ok & is_read_ok & (rx_addr == eic_pkg::REG_DIAG);

   ////////////////////////////////////////////////////////////////////////
   // registers
   eic_pkg::eic_cmd_s cmd_q;
   logic [12:0] diag_q;
   logic [12:0] diag_d;
   logic [12:0] stat_q;
   logic [12:0] stat_d;
   eic_pkg::eic_hdr_s rep_q;
   eic_pkg::eic_hdr_s rep_d;
   eic_pkg::eic_cmd_s cmd_wr;
   logic [12:0] cmd_word;
   logic [12:0] sel_data;
   logic [15:0] reply_word;

   // undefined bits are never stored, so they read back zero
   assign cmd_wr = '{sensor_thresh_sel: rx_q[eic_pkg::CMD_THRESH_LO_POS +: 2],
                     sensor_load_sel: rx_q[eic_pkg::CMD_LOAD_LO_POS +: 2],
                     chan5_on_ctl: rx_q[eic_pkg::CMD_CHAN5_POS],
                     chan4_on_ctl: rx_q[eic_pkg::CMD_CHAN4_POS],
                     chan2_on_ctl: rx_q[eic_pkg::CMD_CHAN2_POS]};

   assign cmd_word = {cmd_q.sensor_thresh_sel, cmd_q.sensor_load_sel, 6'h00,
                      cmd_q.chan5_on_ctl, cmd_q.chan4_on_ctl, cmd_q.chan2_on_ctl};

   // detectors set bits in place; a diagnosis read clears only bits whose cause is gone,
   // and a detection in the clearing cycle wins
   assign diag_d = (do_read_diag ? eic_pkg::DIAG_RST : diag_q) | det_s;

   // one stage past the synchroniser: a change lands a clock after a select edge seen with it
   assign stat_d = {wd_off_s, wd_exp_s, 6'h00, chan_s};

   // short or long frames leave the pending reply alone
   assign rep_d = !(cs_rise && len_ok) ? rep_q :
                  frame_valid ? eic_pkg::eic_hdr_s'{rw: rx_rw, addr: rx_addr} :
                  eic_pkg::eic_hdr_s'{rw: eic_pkg::RW_READ, addr: eic_pkg::REG_DIAG};

   assign sel_data = (rep_q.addr == eic_pkg::REG_DIAG) ? diag_q :
                     (rep_q.addr == eic_pkg::REG_STAT) ? stat_q : cmd_word;
   assign reply_word = {rep_q.rw, rep_q.addr, sel_data};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_q <= eic_pkg::eic_cmd_s'(7'(eic_pkg::CMD_RST));
         diag_q <= eic_pkg::DIAG_RST;
         stat_q <= eic_pkg::STAT_RST;
         rep_q <= '{rw: eic_pkg::RW_READ, addr: eic_pkg::REG_CMD};
      end else begin
         if (do_write) begin
            cmd_q <= cmd_wr;
         end
         diag_q <= diag_d;
         stat_q <= stat_d;
         rep_q <= rep_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rx_q <= 16'h0000;
         cnt_q <= 5'h00;
      end else if (cs_fall) begin
         cnt_q <= 5'h00;
      end else if (sclk_fall) begin
         rx_q <= {rx_q[14:0], si_s};
         // saturate so long frames never wrap back to sixteen
         if (cnt_q != 5'h1F) begin
            cnt_q <= cnt_q + 5'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // serial output: flag before first rise, then reply bits MSB first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_q <= 16'h0000;
         so_q <= 1'h0;
         oe_q <= 1'h0;
      end else if (cs_fall) begin
         tx_q <= reply_word;
         so_q <= |diag_q;
         oe_q <= 1'h1;
      end else if (cs_rise) begin
         so_q <= 1'h0;
         oe_q <= 1'h0;
      end else if (sclk_rise) begin
         so_q <= tx_q[15];
         tx_q <= {tx_q[14:0], 1'h0};
      end
   end

   assign spi_dout_o = so_q;
   assign spi_dout_oe_o = oe_q;
   assign cmd_o = cmd_q;

   ////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic rst_seen_q;
   always_ff @(posedge clk_i) begin
      rst_seen_q <= rst_i;
   end

   a_reset_zero: assert property (rst_seen_q |-> (cmd_word == 13'h0000) && (diag_q == 13'h0000)
                                  && (stat_q == 13'h0000) && (rep_q.addr == eic_pkg::REG_CMD))
      else $error("registers not zero after reset");

   a_flag_level: assert property (cs_fall |=> spi_dout_oe_o && (spi_dout_o == $past(|diag_q)))
      else $error("status flag level wrong after select");

   a_cmd_write: assert property (do_write |=> cmd_q == $past(cmd_wr))
      else $error("command write not stored");

   a_cmd_fields: assert property (do_write |=> (cmd_word[12:9] == $past(rx_q[12:9]))
                                  && (cmd_word[8:3] == 6'h00))
      else $error("command fields misplaced");

   a_read_only: assert property ((cs_rise && len_ok && !is_write_cmd) |=> $stable(cmd_q))
      else $error("command changed without a write");

   a_bad_length: assert property ((cs_rise && !len_ok) |=> $stable(rep_q) && $stable(cmd_q))
      else $error("bad length frame acted on");

   a_invalid_reply: assert property ((cs_rise && len_ok && !frame_valid) |=>
                                     (rep_q.addr == eic_pkg::REG_DIAG) && !rep_q.rw)
      else $error("invalid frame not answered with diagnosis");

   a_reply_load: assert property (cs_fall |=> tx_q == $past(reply_word))
      else $error("reply word not loaded");

   a_shift_out: assert property (sclk_rise |=> spi_dout_o == $past(tx_q[15]))
      else $error("serial bit not shifted out");

   a_diag_sticky: assert property ((det_s[0] && !do_read_diag) |=> diag_q[0])
      else $error("open load bit lost");

   a_diag_set: assert property ((det_s != 13'h0000) |=> ((diag_q & $past(det_s)) == $past(det_s)))
      else $error("detected fault not flagged");

   a_diag_hold: assert property (!do_read_diag |=> ((diag_q & $past(diag_q)) == $past(diag_q)))
      else $error("diagnosis bit dropped without a read");

   a_diag_clear: assert property (do_read_diag |=> (diag_q == $past(det_s)))
      else $error("diagnosis read did not clear absent faults");

   a_stat_chan: assert property (##1 stat_q[4:0] == $past(chan_s))
      else $error("channel states not mirrored");

   a_wd_expired: assert property (##1 stat_q[eic_pkg::STAT_WD_EXP_POS] == $past(wd_exp_s))
      else $error("watchdog expired bit not mirrored");

   a_frame_count: assert property (cs_fall |=> (cnt_q == 5'h00))
      else $error("bit count not cleared at select");

   a_rx_shift: assert property (sclk_fall |=> (rx_q == {$past(rx_q[14:0]), $past(si_s)}))
      else $error("serial input bit not captured");

   a_valid_reply: assert property ((cs_rise && len_ok && frame_valid) |=>
                                   (rep_q.rw == $past(rx_rw)) && (rep_q.addr == $past(rx_addr)))
      else $error("reply header not taken from frame");

   a_so_idle: assert property (!spi_dout_oe_o |-> !spi_dout_o)
      else $error("serial output high while released");

   a_stat_mirror: assert property (##1 stat_q[eic_pkg::STAT_WD_OFF_POS] == $past(wd_off_s))
      else $error("watchdog off bit not mirrored");

   a_oe_release: assert property (cs_rise |=> !spi_dout_oe_o [*2])
      else $error("output still enabled after deselect");

   c_cmd_write: cover property (do_write);
   c_diag_read: cover property (do_read_diag && (diag_q != 13'h0000));
   c_invalid: cover property (cs_rise && len_ok && !frame_valid);
   c_short: cover property (cs_rise && (cnt_q == 5'h0F));
   c_stat_read: cover property (cs_rise && len_ok && is_read_ok && (rx_addr == eic_pkg::REG_STAT));

endmodule : eic_spi_regs
`default_nettype wire

// file: eic_host_model.sv
`default_nettype none
module eic_host_model (
   // link pins
   output logic spi_clk_o,
   output logic spi_cs_n_o,
   output logic spi_din_o,
   input wire logic spi_dout_i,
   input wire logic spi_dout_oe_i
);
   timeunit 1ns;
   timeprecision 100ps;
   logic so_last = 1'b0;
   // undriven output reads as the inverse of its last level, so a stale sample cannot match by luck
   wire logic so_w = spi_dout_oe_i ? spi_dout_i : ~so_last;
   always @(spi_dout_i or spi_dout_oe_i) if (spi_dout_oe_i) so_last = spi_dout_i;
   initial begin
      spi_clk_o = 1'b0;
      spi_cs_n_o = 1'b1;
      spi_din_o = 1'b0;
   end
   //////////////////////////////////////////////////
   // clock idles low at both chip-select edges; nbits other than 16 only for refusal tests
   task automatic frame(input logic [15:0] tx, input int nbits, output logic [15:0] rx, output logic flag);
      rx = 16'h0000;
      spi_cs_n_o = 1'b0;
      #250;
      flag = so_w;
      for (int i = 0; i < nbits; i++) begin
         spi_clk_o = 1'b1;
         spi_din_o = tx[15 - (i % 16)];
         #62.5;
         rx = {rx[14:0], so_w};
         spi_clk_o = 1'b0;
         #62.5;
      end
      #40;
      spi_cs_n_o = 1'b1;
      spi_din_o = ~spi_din_o;
      #600;
   endtask : frame
endmodule : eic_host_model
`default_nettype wire

// file: engine_ic_spi_register_map_test.sv
`default_nettype none
module engine_ic_spi_register_map_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wire logic spi_clk_i, spi_cs_n_i, spi_din_i, spi_dout_o, spi_dout_oe_o;
   logic [12:0] diag_det_i = 13'h0000;
   logic [4:0] chan_on_i = 5'h00;
   logic wd_expired_i = 1'b0;
   logic wd_off_pin_i = 1'b0;
   eic_pkg::eic_cmd_s cmd_o;
   int err_total = 0;
   int check_count = 0;
   logic [15:0] rx;
   logic flag;
   logic [15:0] bad_q[$] = '{16'hA000, 16'hC000, 16'hE000, 16'h6000};
   always #5 clk_i = ~clk_i;
   eic_spi_regs i_dut (.clk_i, .rst_i, .spi_clk_i, .spi_cs_n_i, .spi_din_i, .spi_dout_o, .spi_dout_oe_o,
      .diag_det_i, .chan_on_i, .wd_expired_i, .wd_off_pin_i, .cmd_o);
   eic_host_model i_host (.spi_clk_o(spi_clk_i), .spi_cs_n_o(spi_cs_n_i), .spi_din_o(spi_din_i),
      .spi_dout_i(spi_dout_o), .spi_dout_oe_i(spi_dout_oe_o));
   //////////////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict;
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : print_verdict
   task automatic xfer(input logic [15:0] tx, input int nb = 16);
      i_host.frame(tx, nb, rx, flag);
   endtask : xfer
   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask : tick
   //////////////////////////////////////////////////
   initial begin
      repeat (100000) @(posedge clk_i);
      err_total++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      check(16'(cmd_o), 16'h0000);
      check(16'(spi_dout_oe_o), 16'h0000);
      repeat (3) tick();
      xfer(16'h4000);
      check(rx, 16'h0000);
      check(16'(flag), 16'h0000);
      xfer(16'h2000);
      check(rx, 16'h4000);
      xfer(16'h0000);
      check(rx, 16'h2000);
      // undefined bits set on purpose: they must not stick
      xfer(16'h9FFF);
      check(16'(cmd_o), 16'h007F);
      xfer(16'h0000);
      check(rx, 16'h9E07);
      xfer(16'h0000);
      check(rx, 16'h1E07);
      for (int i = 0; i < 4; i++) begin
         xfer({3'h4, 2'(i), 2'(i), 6'h00, 3'(i)});
         check(16'(cmd_o), {9'h000, 2'(i), 2'(i), 3'(i)});
      end
      tick();
      chan_on_i = 5'h15;
      wd_expired_i = 1'b1;
      wd_off_pin_i = 1'b1;
      xfer(16'h4000);
      xfer(16'h4000);
      check(rx, 16'h5815);
      tick();
      chan_on_i = 5'h0A;
      wd_expired_i = 1'b0;
      wd_off_pin_i = 1'b0;
      repeat (3) tick();
      xfer(16'h0000);
      check(rx, 16'h400A);
      tick();
      diag_det_i = 13'h1555;
      repeat (3) tick();
      xfer(16'h2000);
      check(16'(flag), 16'h0001);
      check(rx, 16'h1E03);
      xfer(16'h0000);
      check(rx, 16'h3555);
      tick();
      diag_det_i = 13'h0AAA;
      xfer(16'h2000);
      tick();
      diag_det_i = 13'h0000;
      xfer(16'h0000);
      check(rx, 16'h2AAA);
      xfer(16'h2000);
      xfer(16'h0000);
      check(16'(flag), 16'h0000);
      check(rx, 16'h2000);
      foreach (bad_q[k]) begin
         xfer(bad_q[k]);
         xfer(16'h0000);
         check(rx, 16'h2000);
         check(16'(cmd_o), 16'h007B);
      end
      xfer(16'h8000, 15);
      check(16'(cmd_o), 16'h007B);
      xfer(16'h8000, 17);
      check(16'(cmd_o), 16'h007B);
      xfer(16'h2000);
      check(rx, 16'h1E03);
      check(16'(spi_dout_oe_o), 16'h0000);
      print_verdict();
   end
endmodule : engine_ic_spi_register_map_test
`default_nettype wire
